// File: verilog/qcp_pkg.sv
// Purpose: Shared constants for the protected low-power handshake.
// Assumes: Both ends run on one clock; pins are synchronous to it.
// Notes: Counts are in device clock cycles.
package qcp_pkg;
	localparam int QCP_CNT_W = 6;
	localparam logic [QCP_CNT_W-1:0] QCP_CNT_RELOAD = 6'h3F;
	localparam logic [QCP_CNT_W-1:0] QCP_CNT_ZERO = 6'h00;
	localparam logic [QCP_CNT_W-1:0] QCP_CNT_STEP = 6'h01;
	localparam int QCP_SAF_COUNTS = 64;
	localparam int QCP_SYNC_STAGES = 2;
	localparam int QCP_MAX_ADDED_LAT = 2;
	localparam int QCP_LANES = 2;
	localparam logic QCP_DISABLE_DEFAULT = 1'b0;
	localparam logic QCP_RST_QREQN = 1'b1;
	localparam logic QCP_RST_QACCEPTN = 1'b1;
	localparam logic QCP_RST_QDENY = 1'b0;
	localparam logic QCP_RST_QACTIVE = 1'b0;
	typedef enum logic [1:0] {
		QCP_DEV_RUN,
		QCP_DEV_STOPPED,
		QCP_DEV_DENIED
	} qcp_dev_state_t;
	typedef enum logic [2:0] {
		QCP_CTL_RUN,
		QCP_CTL_REQ,
		QCP_CTL_STOPPED,
		QCP_CTL_EXIT,
		QCP_CTL_DENIED
	} qcp_ctl_state_t;
endpackage

// File: verilog/qcp_if.sv
// Purpose: Low-power handshake wires with inverted check copies.
// Assumes: Point-to-point wires only, one clock.
// Notes: The controller drives the request pair, the device the rest.
`timescale 1ns/1ps
interface qcp_if;
	logic qreqn;
	logic qreqn_chk;
	logic qactive;
	logic qactive_chk;
	logic qacceptn;
	logic qacceptn_chk;
	logic qdeny;
	logic qdeny_chk;
	modport dev (
		input qreqn,
		input qreqn_chk,
		output qactive,
		output qactive_chk,
		output qacceptn,
		output qacceptn_chk,
		output qdeny,
		output qdeny_chk
	);
	modport ctl (
		output qreqn,
		output qreqn_chk,
		input qactive,
		input qactive_chk,
		input qacceptn,
		input qacceptn_chk,
		input qdeny,
		input qdeny_chk
	);
endinterface

// File: verilog/qcp_controller.sv
// Purpose: Controller end: drives the quiescence request four-phase.
// Assumes: Device outputs are synchronous to clk_i.
// Notes: Each request level is held until the device answers.
`timescale 1ns/1ps
module qcp_controller
	import qcp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Handshake
	qcp_if.ctl q,
	// User side
	input wire logic quiesce_i,
	output logic quiesced_o,
	output logic denied_o,
	output logic dev_active_o,
	output logic chk_fault_o
);
	qcp_ctl_state_t state_ff, nxt_state;
	logic qreqn_ff, nxt_qreqn;
	logic chk_fault_ff;
	wire logic line_bad;

	// Every device line must carry its inverse on the check copy
	assign line_bad = (q.qactive == q.qactive_chk) | (q.qacceptn == q.qacceptn_chk)
		| (q.qdeny == q.qdeny_chk);

	always_comb begin
		nxt_state = state_ff;
		nxt_qreqn = qreqn_ff;
		case (state_ff)
			QCP_CTL_RUN: begin
				if (quiesce_i) begin
					nxt_qreqn = 1'b0;
					nxt_state = QCP_CTL_REQ;
				end
			end
			// Request is held low until accept or deny comes back
			QCP_CTL_REQ: begin
				if (!q.qacceptn) begin
					nxt_state = QCP_CTL_STOPPED;
				end else if (q.qdeny) begin
					nxt_qreqn = 1'b1;
					nxt_state = QCP_CTL_DENIED;
				end
			end
			QCP_CTL_STOPPED: begin
				if (!quiesce_i) begin
					nxt_qreqn = 1'b1;
					nxt_state = QCP_CTL_EXIT;
				end
			end
			QCP_CTL_EXIT: begin
				if (q.qacceptn) begin
					nxt_state = QCP_CTL_RUN;
				end
			end
			QCP_CTL_DENIED: begin
				if (!q.qdeny) begin
					nxt_state = QCP_CTL_RUN;
				end
			end
			default: begin
				nxt_state = QCP_CTL_RUN;
				nxt_qreqn = QCP_RST_QREQN;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= QCP_CTL_RUN;
			qreqn_ff <= QCP_RST_QREQN;
			chk_fault_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			qreqn_ff <= nxt_qreqn;
			chk_fault_ff <= line_bad;
		end
	end

	// Both copies come from one flop, so the pair has no skew here
	assign q.qreqn = qreqn_ff;
	assign q.qreqn_chk = ~qreqn_ff;
	assign quiesced_o = (state_ff == QCP_CTL_STOPPED);
	assign denied_o = (state_ff == QCP_CTL_DENIED);
	assign dev_active_o = q.qactive;
	assign chk_fault_o = chk_fault_ff;
endmodule

// File: verilog/qcp_device.sv
// Purpose: Device end of the low-power handshake with fault protection.
// Assumes: qreqn pair may arrive asynchronously; it is synchronised here.
// Notes: Redundant lanes each filter transients and count stuck mismatches.
// Contract
// - Every handshake line travels with inverted check.
// - Each line checked alone, not as word.
// - Separate synchronisers, then redundant protection lanes.
// - Controller holds assertions until device answers.
// - Short-lived assertions are faults, filtered out.
// - Filtered transients never change power state.
// - Protection adds at most two cycles latency.
// - Stuck fault needs 64 counts of mismatch.
// - Counter reloads to 63 while pair agrees.
// - Mismatch decrements; zero raises error; agreement reloads.
// - One-sided pulse leaves filtered request deasserted.
// - Stuck-at-one on either line raises error.
// - Controller keeps request skew below 64 over ratio.
// - Software enable cannot switch protection off.
// - Tie check to inverse to disable one channel.
// - Global parameter removes all handshake protection; here it only forces pair agreement, and the lane compare and hold remain.
// - Request in; active, accept, deny out.
`timescale 1ns/1ps
module qcp_device
	import qcp_pkg::*;
#(
	parameter logic DISABLE_ALL_HANDSHAKE_PROTECTION = QCP_DISABLE_DEFAULT,
	parameter int SYNC_STAGES = QCP_SYNC_STAGES
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Handshake
	qcp_if.dev q,
	// Mission side
	input wire logic component_active_i,
	input wire logic deny_i,
	input wire logic safety_mechanism_enable_reg_i,
	output logic qreqn_int_o,
	output logic quiesced_o,
	// Fault reporting
	output logic stuck_fault_o,
	output logic lane_fault_o,
	output logic [QCP_CNT_W-1:0] count_o
);
	// Elaboration checks
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("SYNC_STAGES must be at least two");
	end
	if (QCP_SAF_COUNTS != (1 << QCP_CNT_W)) begin : g_bad_cnt
		$error("Counter width does not match the stuck-fault count");
	end

	// Separate synchronisers for the request and its check copy
	logic [SYNC_STAGES-1:0] req_sync_ff;
	logic [SYNC_STAGES-1:0] chk_sync_ff;
	wire logic req_s;
	wire logic chk_s;
	wire logic pair_agree;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_sync_ff <= {SYNC_STAGES{QCP_RST_QREQN}};
			chk_sync_ff <= {SYNC_STAGES{~QCP_RST_QREQN}};
		end else begin
			req_sync_ff <= {req_sync_ff[SYNC_STAGES-2:0], q.qreqn};
			chk_sync_ff <= {chk_sync_ff[SYNC_STAGES-2:0], q.qreqn_chk};
		end
	end

	assign req_s = req_sync_ff[SYNC_STAGES-1];
	assign chk_s = chk_sync_ff[SYNC_STAGES-1];
	// The request is compared with its own check only, never grouped
	assign pair_agree = (req_s != chk_s);

	// Redundant lanes: lane 0 reads the request, lane 1 the inverted check
	// Nets, so that each lane drives only its own element
	wire logic [QCP_LANES-1:0] lane_int;
	wire logic [QCP_LANES-1:0] lane_err;
	wire logic [QCP_CNT_W-1:0] lane_cnt [QCP_LANES];

	for (genvar i = 0; i < QCP_LANES; i++) begin : g_lane
		logic int_ff, nxt_int;
		logic err_ff, nxt_err;
		logic [QCP_CNT_W-1:0] cnt_ff, nxt_cnt;
		wire logic lane_in;
		wire logic lane_agree;
		wire logic at_zero;

		assign lane_in = (i == 0) ? req_s : ~chk_s;
		assign lane_agree = DISABLE_ALL_HANDSHAKE_PROTECTION | pair_agree;
		assign at_zero = (cnt_ff == QCP_CNT_ZERO);

		// A lone pulse on one wire breaks agreement and is never taken
		assign nxt_int = lane_agree ? lane_in : int_ff;

		// Reload while agreeing, count down while not, stop at zero
		assign nxt_cnt = lane_agree ? QCP_CNT_RELOAD
			: (at_zero ? QCP_CNT_ZERO : cnt_ff - QCP_CNT_STEP);

		// Sticky: set on the mismatch cycle seen at zero, cleared only by reset
		assign nxt_err = err_ff | (~lane_agree & at_zero);

		always_ff @(posedge clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				int_ff <= QCP_RST_QREQN;
				cnt_ff <= QCP_CNT_RELOAD;
				err_ff <= 1'b0;
			end else begin
				int_ff <= nxt_int;
				cnt_ff <= nxt_cnt;
				err_ff <= nxt_err;
			end
		end

		assign lane_int[i] = int_ff;
		assign lane_err[i] = err_ff;
		assign lane_cnt[i] = cnt_ff;
	end

	// Lanes disagreeing means one of them is broken; hold the old request
	wire logic lanes_match;
	wire logic qreqn_filt;
	logic qreqn_filt_ff;
	logic lane_fault_ff;

	assign lanes_match = (lane_int[0] == lane_int[1]);
	assign qreqn_filt = lanes_match ? lane_int[0] : qreqn_filt_ff;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			qreqn_filt_ff <= QCP_RST_QREQN;
			lane_fault_ff <= 1'b0;
		end else begin
			qreqn_filt_ff <= qreqn_filt;
			lane_fault_ff <= lane_fault_ff | ~lanes_match;
		end
	end

	// Power state machine sees only the filtered request
	qcp_dev_state_t state_ff, nxt_state;
	logic qacceptn_ff, nxt_qacceptn;
	logic qdeny_ff, nxt_qdeny;
	logic qactive_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_qacceptn = qacceptn_ff;
		nxt_qdeny = qdeny_ff;
		case (state_ff)
			QCP_DEV_RUN: begin
				if (!qreqn_filt) begin
					if (deny_i) begin
						nxt_qdeny = 1'b1;
						nxt_state = QCP_DEV_DENIED;
					end else begin
						nxt_qacceptn = 1'b0;
						nxt_state = QCP_DEV_STOPPED;
					end
				end
			end
			QCP_DEV_STOPPED: begin
				if (qreqn_filt) begin
					nxt_qacceptn = 1'b1;
					nxt_state = QCP_DEV_RUN;
				end
			end
			QCP_DEV_DENIED: begin
				if (qreqn_filt) begin
					nxt_qdeny = 1'b0;
					nxt_state = QCP_DEV_RUN;
				end
			end
			default: begin
				nxt_state = QCP_DEV_RUN;
				nxt_qacceptn = QCP_RST_QACCEPTN;
				nxt_qdeny = QCP_RST_QDENY;
			end
		endcase
	end

	// One output flop: one cycle added on the way out, within the budget
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= QCP_DEV_RUN;
			qacceptn_ff <= QCP_RST_QACCEPTN;
			qdeny_ff <= QCP_RST_QDENY;
			qactive_ff <= QCP_RST_QACTIVE;
		end else begin
			state_ff <= nxt_state;
			qacceptn_ff <= nxt_qacceptn;
			qdeny_ff <= nxt_qdeny;
			qactive_ff <= component_active_i;
		end
	end

	// Check copies come from the same flops, so they launch together
	assign q.qactive = qactive_ff;
	assign q.qactive_chk = ~qactive_ff;
	assign q.qacceptn = qacceptn_ff;
	assign q.qacceptn_chk = ~qacceptn_ff;
	assign q.qdeny = qdeny_ff;
	assign q.qdeny_chk = ~qdeny_ff;

	// Software enable is deliberately ignored by all protection above
	wire logic unused_smen;
	assign unused_smen = safety_mechanism_enable_reg_i;

	assign qreqn_int_o = qreqn_filt_ff;
	assign quiesced_o = (state_ff == QCP_DEV_STOPPED);
	assign stuck_fault_o = |lane_err;
	assign lane_fault_o = lane_fault_ff;
	assign count_o = lane_cnt[0];
endmodule

// File: dv/qcp_chk.sv
// Purpose: Concurrent checks on the handshake wires.
// Assumes: One clock, async active-low reset.
// Notes: Latency windows allow sync, lane flop and output flop.
`timescale 1ns/1ps
module qcp_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Handshake
	input wire logic qreqn,
	input wire logic qreqn_chk,
	input wire logic qactive,
	input wire logic qactive_chk,
	input wire logic qacceptn,
	input wire logic qacceptn_chk,
	input wire logic qdeny,
	input wire logic qdeny_chk
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	chk_req_inverse: assert property (qreqn_chk == !qreqn)
		else $error("request check copy not inverse");
	chk_ans_inverse: assert property (qacceptn_chk == !qacceptn && qdeny_chk == !qdeny
		&& qactive_chk == !qactive)
		else $error("answer check copy not inverse");
	chk_enter_latency: assert property ($fell(qreqn) |-> ##[2:4] (!qacceptn || qdeny))
		else $error("entry answer late");
	chk_exit_latency: assert property ($rose(qreqn) |-> ##[2:4] (qacceptn && !qdeny))
		else $error("exit answer late");
	chk_accept_cause: assert property ($fell(qacceptn) |-> !qreqn && !$past(qreqn, 3))
		else $error("accept without held request");
	chk_deny_cause: assert property ($rose(qdeny) |-> !qreqn && !$past(qreqn, 3))
		else $error("deny without held request");
	chk_accept_hold: assert property (!qacceptn && !qreqn |=> !qacceptn)
		else $error("accept dropped while request held");
	chk_deny_hold: assert property (qdeny && !qreqn |=> qdeny)
		else $error("deny dropped while request held");
	chk_one_answer: assert property (!(!qacceptn && qdeny))
		else $error("accept and deny together");
endmodule

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the protected handshake.
// Assumes: Second device pair is driven by the bench to inject faults.
// Notes: Fixed seed so every run repeats.
`timescale 1ns/1ps
module tb_top;
	import qcp_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic quiesce_i = 1'b0;
	logic act_i = 1'b0;
	logic deny_i = 1'b0;
	logic smen_i = 1'b0;
	logic quiesced, denied, dev_act, chk_flt, dq, fq, fint, fstuck, qint0, stuck0, lflt0, lflt1, dstuck;
	logic glitch = 1'b0;
	logic glitch_arm = 1'b0;
	logic [QCP_CNT_W-1:0] fcnt, cnt0, dcnt;
	int err_total = 0;
	int checked = 0;
	int n;
	qcp_if i0 ();
	qcp_if i1 ();
	qcp_if i2 ();
	// Protection-disabled device sees the same broken pins as the fault pair
	assign i2.qreqn = i1.qreqn;
	assign i2.qreqn_chk = i1.qreqn_chk;
	always #4 clk_i = ~clk_i;
	qcp_controller i_qcp_controller (.clk_i(clk_i), .resetn_i(resetn_i), .q(i0.ctl), .quiesce_i(quiesce_i),
		.quiesced_o(quiesced), .denied_o(denied), .dev_active_o(dev_act), .chk_fault_o(chk_flt));
	qcp_device i_qcp_device (.clk_i(clk_i), .resetn_i(resetn_i), .q(i0.dev), .component_active_i(act_i),
		.deny_i(deny_i), .safety_mechanism_enable_reg_i(smen_i), .qreqn_int_o(qint0), .quiesced_o(dq),
		.stuck_fault_o(stuck0), .lane_fault_o(lflt0), .count_o(cnt0));
	// Fault pair: bench plays a broken controller here
	qcp_device i_qcp_device_f (.clk_i(clk_i), .resetn_i(resetn_i), .q(i1.dev), .component_active_i(act_i),
		.deny_i(deny_i), .safety_mechanism_enable_reg_i(smen_i), .qreqn_int_o(fint), .quiesced_o(fq),
		.stuck_fault_o(fstuck), .lane_fault_o(lflt1), .count_o(fcnt));
	qcp_device #(.DISABLE_ALL_HANDSHAKE_PROTECTION(1'b1)) i_qcp_device_d (.clk_i(clk_i), .resetn_i(resetn_i),
		.q(i2.dev), .component_active_i(act_i), .deny_i(deny_i), .safety_mechanism_enable_reg_i(smen_i),
		.qreqn_int_o(), .quiesced_o(), .stuck_fault_o(dstuck), .lane_fault_o(), .count_o(dcnt));
	qcp_chk i_qcp_chk (.clk_i(clk_i), .resetn_i(resetn_i), .qreqn(i0.qreqn), .qreqn_chk(i0.qreqn_chk),
		.qactive(i0.qactive), .qactive_chk(i0.qactive_chk), .qacceptn(i0.qacceptn),
		.qacceptn_chk(i0.qacceptn_chk), .qdeny(i0.qdeny), .qdeny_chk(i0.qdeny_chk));
	// Sampled on the falling edge, where the outputs have settled
	always @(negedge clk_i) glitch <= glitch_arm & (glitch | (fint !== 1'b1) | (fq !== 1'b0));
	task automatic cmp(input string nm, input logic [5:0] e, input logic [5:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic hs(input logic d);
		deny_i = d;
		act_i = 1'($urandom);
		quiesce_i = 1'b1;
		for (n = 0; n < 20 && quiesced !== 1'b1 && denied !== 1'b1; n++) step(1);
		if (n == 20) begin
			err_total++;
			close_out();
		end
		cmp("denied", {5'h00, d}, {5'h00, denied});
		cmp("quiesced", {5'h00, !d}, {5'h00, quiesced});
		cmp("device quiesced", {5'h00, !d}, {5'h00, dq});
		cmp("active", {5'h00, act_i}, {5'h00, dev_act});
		cmp("check fault", 6'h00, {5'h00, chk_flt});
		cmp("device filtered req", 6'h00, {5'h00, qint0});
		cmp("device stuck", 6'h00, {5'h00, stuck0});
		cmp("device count", 6'h3F, cnt0);
		quiesce_i = 1'b0;
		for (n = 0; n < 20 && (quiesced !== 1'b0 || denied !== 1'b0 || i0.qacceptn !== 1'b1); n++) step(1);
		if (n == 20) begin
			err_total++;
			close_out();
		end
		step(2);
		$display("handshake done deny=%0d", d);
	endtask
	// Only one wire of the pair moves; the other holds idle
	task automatic pulse(input logic v, input int w);
		i1.qreqn = v;
		i1.qreqn_chk = v;
		step(w);
		i1.qreqn = 1'b1;
		i1.qreqn_chk = 1'b0;
		step(8);
		cmp("filtered req", 6'h01, {5'h00, fint});
		cmp("count", 6'h3F, fcnt);
		$display("pulse done width=%0d", w);
	endtask
	initial begin
		void'($urandom(96378));
		i1.qreqn = 1'b1;
		i1.qreqn_chk = 1'b0;
		step(12);
		resetn_i = 1'b1;
		step(2);
		hs(1'b0);
		hs(1'b1);
		repeat (10) begin
			smen_i = 1'($urandom);
			hs(1'($urandom));
		end
		glitch_arm = 1'b1;
		for (int k = 0; k < 8; k++) pulse(k[0], 1 + $urandom % 8);
		cmp("no state change", 6'h00, {5'h00, glitch});
		glitch_arm = 1'b0;
		deny_i = 1'b0;
		i1.qreqn = 1'b0;
		i1.qreqn_chk = 1'b1;
		step(4);
		cmp("accept", 6'h02, {4'h0, i1.qacceptn_chk, i1.qacceptn});
		cmp("disabled accept", 6'h00, {5'h00, i2.qacceptn});
		i1.qreqn = 1'b1;
		i1.qreqn_chk = 1'b0;
		step(4);
		cmp("release", 6'h01, {5'h00, i1.qacceptn});
		smen_i = 1'b0;
		i1.qreqn_chk = 1'b1;
		step(62);
		cmp("stuck early", 6'h00, {5'h00, fstuck});
		cmp("count down", 6'h03, fcnt);
		step(8);
		cmp("stuck", 6'h01, {5'h00, fstuck});
		i1.qreqn_chk = 1'b0;
		step(10);
		cmp("stuck sticky", 6'h01, {5'h00, fstuck});
		cmp("reload", 6'h3F, fcnt);
		cmp("disabled stuck", 6'h00, {5'h00, dstuck});
		cmp("disabled count", 6'h3F, dcnt);
		cmp("lane fault", 6'h00, {4'h0, lflt0, lflt1});
		resetn_i = 1'b0;
		step(2);
		cmp("reset stuck", 6'h00, {5'h00, fstuck});
		cmp("reset count", 6'h3F, fcnt);
		resetn_i = 1'b1;
		step(4);
		cmp("after reset", 6'h01, {5'h00, fint});
		$display("fault tests done");
		close_out();
	end
endmodule
